/* File: pkg/ssrl_pkg.sv */
/*
 status service request logic package: bit positions, masks, reset values,
 register select codes, carrier structs.
 assumes a command decoder on core_clk that issues one-cycle strobes.
*/
package ssrl_pkg;
   // status byte positions
   localparam int SB_MEAS = 0;
   localparam int SB_ERR = 2;
   localparam int SB_QUES = 3;
   localparam int SB_MSG = 4;
   localparam int SB_STD = 5;
   localparam int SB_RQS = 6;
   localparam int SB_OPER = 7;
   // standard event positions
   localparam int SE_OPC = 0;
   localparam int SE_QYE = 2;
   localparam int SE_DEV = 3;
   localparam int SE_EXE = 4;
   localparam int SE_CMD = 5;
   localparam int SE_LOCAL = 6;
   localparam int SE_PON = 7;
   // operation event positions
   localparam int OE_SELFADJ = 0;
   localparam int OE_AVOHM = 1;
   localparam int OE_SWEEP = 3;
   localparam int OE_TRIG = 5;
   localparam int OE_ARM = 6;
   localparam int OE_IDLE = 10;
   // measurement event positions
   localparam int ME_LL1 = 1;
   localparam int ME_HL1 = 2;
   localparam int ME_LL2 = 3;
   localparam int ME_HL2 = 4;
   localparam int ME_PASS = 5;
   localparam int ME_RDY = 6;
   localparam int ME_OVF = 7;
   localparam int ME_BAV = 8;
   localparam int ME_BFL = 9;
   localparam int ME_IOV = 10;
   localparam int ME_LOCK = 11;
   localparam int ME_VSC = 14;
   // questionable positions
   localparam int QE_CAL = 7;
   localparam int QE_WARN = 14;
   // used-bit masks
   localparam logic [7:0] SB_USED_MASK = 8'hBD;
   localparam logic [7:0] STD_USED_MASK = 8'hFD;
   localparam logic [15:0] OPER_USED_MASK = 16'h046B;
   localparam logic [15:0] MEAS_USED_MASK = 16'h4FFE;
   localparam logic [15:0] QUES_USED_MASK = 16'h4080;
   // reset values
   localparam logic [7:0] SRE_RESET = 8'h00;
   localparam logic [7:0] STD_RESET = 8'h80;
   localparam logic [15:0] EVT_RESET = 16'h0000;
   // register select codes
   typedef enum logic [2:0] {
      SSRL_SEL_STD = 3'h0,
      SSRL_SEL_OPER = 3'h1,
      SSRL_SEL_MEAS = 3'h2,
      SSRL_SEL_QUES = 3'h3,
      SSRL_SEL_SRE = 3'h4,
      SSRL_SEL_STB = 3'h5
   } ssrl_sel_t;

   typedef struct packed {
      logic [7:0] std;
      logic [15:0] oper;
      logic [15:0] meas;
      logic [15:0] ques;
   } ssrl_events_t;

   typedef struct packed {
      logic [7:0] std;
      logic [15:0] oper;
      logic [15:0] meas;
      logic [15:0] ques;
   } ssrl_enables_t;
endpackage

/* File: src/ssrl_event_set.sv */
/*
 one latched event register set: sticky flags, read-to-clear, summary.
 assumes set and clear strobes are on core_clk.
*/
`timescale 1ns/1ns
module ssrl_event_set #(
   parameter int W = 16,
   parameter logic [W-1:0] USED = '1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [W-1:0] set_bits,
   input wire logic clear,
   input wire logic [W-1:0] enable,
   output logic [W-1:0] flags,
   output logic summary
);
   typedef struct packed {
      logic [W-1:0] flags;
   } ssrl_set_state_t;
   ssrl_set_state_t st_reg;
   ssrl_set_state_t st_next;

   always_comb begin
      st_next = st_reg;
      // set wins over the clear so no event is lost
      if (clear) begin
         st_next.flags = '0;
      end
      st_next.flags = (st_next.flags | set_bits) & USED;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_reg <= '{flags: RST & USED};
      end else begin
         st_reg <= st_next;
      end
   end

   assign flags = st_reg.flags;
   assign summary = |(st_reg.flags & enable);

   a_sticky_flag: assert property (@(posedge core_clk) disable iff (rst)
      (!$past(clear) && !$past(rst)) |-> ((flags & $past(flags)) == $past(flags)))
      else $error("event flag dropped without clear");
endmodule // ssrl_event_set

/* File: src/ssrl_status_core.sv */
/*
 status byte and service request logic: four event sets, enables, service
 request enable mask, request bit and service request line, serial poll.
 assumes a command decoder on core_clk giving one-cycle strobes; event
 inputs are same-domain pulses or levels from instrument logic.
*/
`timescale 1ns/1ns
module ssrl_status_core (
   input wire logic core_clk,
   input wire logic rst,
   // register access from the command decoder
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire ssrl_pkg::ssrl_sel_t reg_sel,
   input wire logic [15:0] reg_wdata,
   input wire logic en_sel,
   output logic [15:0] reg_rdata,
   input wire logic clear_status,
   input wire logic status_preset,
   // serial poll
   input wire logic poll_done,
   output logic [7:0] poll_byte,
   output logic service_request,
   // standard event causes
   input wire logic opc_query,
   input wire logic ops_pending,
   input wire logic empty_queue_read,
   input wire logic device_error,
   input wire logic exec_error,
   input wire logic syntax_error,
   input wire logic semantic_error,
   input wire logic trigger_in_message,
   input wire logic local_key,
   // operation causes
   input wire logic self_adjust,
   input wire logic av_ohms_running,
   input wire logic sweep_running,
   input wire logic awaiting_trigger_bus,
   input wire logic awaiting_arm,
   input wire logic idle,
   // measurement causes
   input wire logic low_limit1_fail,
   input wire logic high_limit1_fail,
   input wire logic low_limit2_fail,
   input wire logic high_limit2_fail,
   input wire logic limits_pass,
   input wire logic reading_ready,
   input wire logic reading_overflow,
   input wire logic buffer_has_two,
   input wire logic buffer_full,
   input wire logic sweep_done,
   input wire logic av_cycles_done,
   input wire logic input_overvoltage,
   input wire logic output_lockout,
   input wire logic source_in_compliance,
   // questionable causes
   input wire logic bad_trim_constant,
   input wire logic calibration_ok,
   input wire logic param_ignored,
   // queue summaries
   input wire logic error_pending,
   input wire logic message_pending
);
   typedef struct packed {
      logic [7:0] service_request_mask;
      ssrl_pkg::ssrl_enables_t en;
      logic poll_request_flag;
      logic [7:0] enabled_prev;
      logic [3:0] hit_prev;
      logic [3:0] hit_new;
      logic opc_wait;
      logic [15:0] rdata;
   } ssrl_core_state_t;
   ssrl_core_state_t st_reg;
   ssrl_core_state_t st_next;

   ssrl_pkg::ssrl_events_t ev_set;
   ssrl_pkg::ssrl_events_t flags;
   logic [3:0] rd_clear;
   logic std_sum;
   logic oper_sum;
   logic meas_sum;
   logic ques_sum;
   logic [7:0] status_summ;
   logic master_summary;
   logic [3:0] set_hit;
   logic [7:0] sb_enabled;
   logic [7:0] sb_fresh;
   logic request_rise;

   function automatic logic sel_hit(input ssrl_pkg::ssrl_sel_t s,
                                    input ssrl_pkg::ssrl_sel_t want);
      sel_hit = (s == want);
   endfunction

   // event sources into set vectors
   always_comb begin
      ev_set = '0;
      // opc waits for pending work; query arms it
      ev_set.std[ssrl_pkg::SE_OPC] = st_reg.opc_wait && !ops_pending;
      ev_set.std[ssrl_pkg::SE_QYE] = empty_queue_read;
      ev_set.std[ssrl_pkg::SE_DEV] = device_error;
      ev_set.std[ssrl_pkg::SE_EXE] = exec_error;
      ev_set.std[ssrl_pkg::SE_CMD] = syntax_error | semantic_error
                                     | trigger_in_message;
      ev_set.std[ssrl_pkg::SE_LOCAL] = local_key;
      ev_set.oper[ssrl_pkg::OE_SELFADJ] = self_adjust;
      ev_set.oper[ssrl_pkg::OE_AVOHM] = av_ohms_running;
      ev_set.oper[ssrl_pkg::OE_SWEEP] = sweep_running;
      ev_set.oper[ssrl_pkg::OE_TRIG] = awaiting_trigger_bus;
      ev_set.oper[ssrl_pkg::OE_ARM] = awaiting_arm;
      ev_set.oper[ssrl_pkg::OE_IDLE] = idle;
      ev_set.meas[ssrl_pkg::ME_LL1] = low_limit1_fail;
      ev_set.meas[ssrl_pkg::ME_HL1] = high_limit1_fail;
      ev_set.meas[ssrl_pkg::ME_LL2] = low_limit2_fail;
      ev_set.meas[ssrl_pkg::ME_HL2] = high_limit2_fail;
      ev_set.meas[ssrl_pkg::ME_PASS] = limits_pass;
      ev_set.meas[ssrl_pkg::ME_RDY] = reading_ready;
      ev_set.meas[ssrl_pkg::ME_OVF] = reading_overflow;
      ev_set.meas[ssrl_pkg::ME_BAV] = buffer_has_two;
      ev_set.meas[ssrl_pkg::ME_BFL] = buffer_full | sweep_done
                                      | av_cycles_done;
      ev_set.meas[ssrl_pkg::ME_IOV] = input_overvoltage;
      ev_set.meas[ssrl_pkg::ME_LOCK] = output_lockout;
      ev_set.meas[ssrl_pkg::ME_VSC] = source_in_compliance;
      // a level: held while the trim fault stands, until calibration passes
      ev_set.ques[ssrl_pkg::QE_CAL] = bad_trim_constant && !calibration_ok;
      ev_set.ques[ssrl_pkg::QE_WARN] = param_ignored;
   end

   // reads of event registers clear them; clear-status clears all four
   always_comb begin
      rd_clear = '0;
      if (reg_rd && !en_sel) begin
         rd_clear[0] = sel_hit(reg_sel, ssrl_pkg::SSRL_SEL_STD);
         rd_clear[1] = sel_hit(reg_sel, ssrl_pkg::SSRL_SEL_OPER);
         rd_clear[2] = sel_hit(reg_sel, ssrl_pkg::SSRL_SEL_MEAS);
         rd_clear[3] = sel_hit(reg_sel, ssrl_pkg::SSRL_SEL_QUES);
      end
   end

   ssrl_event_set #(.W(8), .USED(ssrl_pkg::STD_USED_MASK), .RST(ssrl_pkg::STD_RESET))
      u_std (.core_clk(core_clk), .rst(rst), .set_bits(ev_set.std),
             .clear(rd_clear[0] | clear_status), .enable(st_reg.en.std),
             .flags(flags.std), .summary(std_sum));
   ssrl_event_set #(.W(16), .USED(ssrl_pkg::OPER_USED_MASK), .RST(ssrl_pkg::EVT_RESET))
      u_oper (.core_clk(core_clk), .rst(rst), .set_bits(ev_set.oper),
              .clear(rd_clear[1] | clear_status), .enable(st_reg.en.oper),
              .flags(flags.oper), .summary(oper_sum));
   ssrl_event_set #(.W(16), .USED(ssrl_pkg::MEAS_USED_MASK), .RST(ssrl_pkg::EVT_RESET))
      u_meas (.core_clk(core_clk), .rst(rst), .set_bits(ev_set.meas),
              .clear(rd_clear[2] | clear_status), .enable(st_reg.en.meas),
              .flags(flags.meas), .summary(meas_sum));
   ssrl_event_set #(.W(16), .USED(ssrl_pkg::QUES_USED_MASK), .RST(ssrl_pkg::EVT_RESET))
      u_ques (.core_clk(core_clk), .rst(rst), .set_bits(ev_set.ques),
              .clear(rd_clear[3] | clear_status), .enable(st_reg.en.ques),
              .flags(flags.ques), .summary(ques_sum));

   // live summaries, no latching here
   always_comb begin
      status_summ = '0;
      status_summ[ssrl_pkg::SB_MEAS] = meas_sum;
      status_summ[ssrl_pkg::SB_ERR] = error_pending;
      status_summ[ssrl_pkg::SB_QUES] = ques_sum;
      status_summ[ssrl_pkg::SB_MSG] = message_pending;
      status_summ[ssrl_pkg::SB_STD] = std_sum;
      status_summ[ssrl_pkg::SB_OPER] = oper_sum;
   end

   // bit 6 of the mask is meaningless as a summary source, masked out
   assign master_summary = |(status_summ & st_reg.service_request_mask
                             & ssrl_pkg::SB_USED_MASK);

   // enabled events this cycle, one bit per set: std, oper, meas, ques
   assign set_hit = {|(ev_set.ques & st_reg.en.ques), |(ev_set.meas & st_reg.en.meas),
                     |(ev_set.oper & st_reg.en.oper), |(ev_set.std & st_reg.en.std)};
   assign sb_enabled = status_summ & st_reg.service_request_mask & ssrl_pkg::SB_USED_MASK;

   // a latched flag hides a repeat of its own event from the summary edge,
   // so repeats are caught at the input and applied a cycle later, with the flag
   always_comb begin
      sb_fresh = sb_enabled & ~st_reg.enabled_prev;
      sb_fresh[ssrl_pkg::SB_STD] |= sb_enabled[ssrl_pkg::SB_STD] & st_reg.hit_new[0];
      sb_fresh[ssrl_pkg::SB_OPER] |= sb_enabled[ssrl_pkg::SB_OPER] & st_reg.hit_new[1];
      sb_fresh[ssrl_pkg::SB_MEAS] |= sb_enabled[ssrl_pkg::SB_MEAS] & st_reg.hit_new[2];
      sb_fresh[ssrl_pkg::SB_QUES] |= sb_enabled[ssrl_pkg::SB_QUES] & st_reg.hit_new[3];
   end
   assign request_rise = |sb_fresh;

   always_comb begin
      st_next = st_reg;
      st_next.enabled_prev = sb_enabled;
      st_next.hit_prev = set_hit;
      st_next.hit_new = set_hit & ~st_reg.hit_prev;
      // any fresh enabled source requests; poll clears; set wins over poll
      if (request_rise) begin
         st_next.poll_request_flag = 1'b1;
      end else if (poll_done) begin
         st_next.poll_request_flag = 1'b0;
      end
      if (!master_summary) begin
         st_next.poll_request_flag = 1'b0;
      end
      if (opc_query) begin
         st_next.opc_wait = 1'b1;
      end else if (!ops_pending) begin
         st_next.opc_wait = 1'b0;
      end
      if (reg_wr) begin
         if (sel_hit(reg_sel, ssrl_pkg::SSRL_SEL_SRE)) begin
            // zero write clears; each bit taken as written
            st_next.service_request_mask = reg_wdata[7:0];
         end else if (sel_hit(reg_sel, ssrl_pkg::SSRL_SEL_STD)) begin
            st_next.en.std = reg_wdata[7:0] & ssrl_pkg::STD_USED_MASK;
         end else if (sel_hit(reg_sel, ssrl_pkg::SSRL_SEL_OPER)) begin
            st_next.en.oper = reg_wdata & ssrl_pkg::OPER_USED_MASK;
         end else if (sel_hit(reg_sel, ssrl_pkg::SSRL_SEL_MEAS)) begin
            st_next.en.meas = reg_wdata & ssrl_pkg::MEAS_USED_MASK;
         end else if (sel_hit(reg_sel, ssrl_pkg::SSRL_SEL_QUES)) begin
            st_next.en.ques = reg_wdata & ssrl_pkg::QUES_USED_MASK;
         end
      end
      // preset clears the four set enables only, never the request mask
      if (status_preset) begin
         st_next.en = '0;
      end
      if (reg_rd) begin
         case (reg_sel)
            ssrl_pkg::SSRL_SEL_STD: begin
               st_next.rdata = en_sel ? {8'h00, st_reg.en.std} : {8'h00, flags.std};
            end
            ssrl_pkg::SSRL_SEL_OPER: begin
               st_next.rdata = en_sel ? st_reg.en.oper : flags.oper;
            end
            ssrl_pkg::SSRL_SEL_MEAS: begin
               st_next.rdata = en_sel ? st_reg.en.meas : flags.meas;
            end
            ssrl_pkg::SSRL_SEL_QUES: begin
               st_next.rdata = en_sel ? st_reg.en.ques : flags.ques;
            end
            ssrl_pkg::SSRL_SEL_SRE: begin
               st_next.rdata = {8'h00, st_reg.service_request_mask};
            end
            ssrl_pkg::SSRL_SEL_STB: begin
               // query form shows master summary in bit 6
               st_next.rdata = {8'h00, status_summ | {1'b0, master_summary, 6'h00}};
            end
            default: begin
               st_next.rdata = 16'h0000;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_reg <= '{service_request_mask: ssrl_pkg::SRE_RESET,
                     en: '0, poll_request_flag: 1'b0, enabled_prev: 8'h00,
                     hit_prev: 4'h0, hit_new: 4'h0, opc_wait: 1'b0,
                     rdata: 16'h0000};
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata = st_reg.rdata;
   // poll form shows the request flag in bit 6
   assign poll_byte = status_summ | {1'b0, st_reg.poll_request_flag, 6'h00};
   assign service_request = st_reg.poll_request_flag;

   a_mask_write: assert property (@(posedge core_clk) disable iff (rst)
      (reg_wr && reg_sel == ssrl_pkg::SSRL_SEL_SRE)
      |=> st_reg.service_request_mask == $past(reg_wdata[7:0]))
      else $error("request mask not stored as written");
   a_mask_reset: assert property (@(posedge core_clk) disable iff (rst)
      $past(rst) |-> st_reg.service_request_mask == ssrl_pkg::SRE_RESET)
      else $error("request mask not cleared by reset");
   a_mask_keep: assert property (@(posedge core_clk) disable iff (rst)
      ((clear_status || status_preset) && !reg_wr) |=> $stable(st_reg.service_request_mask))
      else $error("request mask changed by clear or preset");
   a_rise_request: assert property (@(posedge core_clk) disable iff (rst)
      request_rise |=> service_request)
      else $error("no request after enabled summary rose");
   a_poll_clears: assert property (@(posedge core_clk) disable iff (rst)
      (poll_done && !request_rise) |=> !service_request)
      else $error("poll did not clear request flag");
   a_rerequest: assert property (@(posedge core_clk) disable iff (rst)
      (poll_done ##1 (!master_summary) ##1 master_summary) |=> service_request)
      else $error("fresh request lost after poll");
   a_fresh_repeat: assert property (@(posedge core_clk) disable iff (rst)
      (st_reg.hit_new[2] && sb_enabled[ssrl_pkg::SB_MEAS]) |=> service_request)
      else $error("repeat of a latched event did not request");
   a_master_live: assert property (@(posedge core_clk) disable iff (rst)
      reg_rd && reg_sel == ssrl_pkg::SSRL_SEL_STB
      |=> reg_rdata[ssrl_pkg::SB_RQS] == $past(master_summary))
      else $error("master summary wrong in status byte read");
   a_req_needs_master: assert property (@(posedge core_clk) disable iff (rst)
      service_request |-> $past(master_summary))
      else $error("request without master summary");
   a_flag_drops: assert property (@(posedge core_clk) disable iff (rst)
      !master_summary |=> !service_request)
      else $error("request stands without master summary");
   a_opc_only_query: assert property (@(posedge core_clk) disable iff (rst)
      (!st_reg.opc_wait) |=> !u_std.st_reg.flags[ssrl_pkg::SE_OPC]
      || $past(u_std.st_reg.flags[ssrl_pkg::SE_OPC]))
      else $error("operation complete set without query");
   a_query_error: assert property (@(posedge core_clk) disable iff (rst)
      empty_queue_read |=> flags.std[ssrl_pkg::SE_QYE])
      else $error("query error bit not set");
   a_cmd_error: assert property (@(posedge core_clk) disable iff (rst)
      (syntax_error || semantic_error || trigger_in_message)
      |=> flags.std[ssrl_pkg::SE_CMD])
      else $error("command error bit not set");
   a_buf_full: assert property (@(posedge core_clk) disable iff (rst)
      (buffer_full || sweep_done || av_cycles_done)
      |=> flags.meas[ssrl_pkg::ME_BFL])
      else $error("buffer full bit not set");
   a_unused_zero: assert property (@(posedge core_clk) disable iff (rst)
      (poll_byte & ~ssrl_pkg::SB_USED_MASK & 8'hBF) == 8'h00)
      else $error("unused status byte bit set");
endmodule // ssrl_status_core

/* File: tb/ssrl_poll_ctrl.sv */
/*
 bus controller model: serial polls the status block on request.
 assumes core_clk domain; bench raises poll_go and sets the reply delay.
*/
`timescale 1ns/1ns
module ssrl_poll_ctrl (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic poll_go,
   input wire logic [3:0] poll_wait,
   input wire logic [7:0] poll_byte,
   output logic poll_done,
   output logic [7:0] last_byte,
   output logic [7:0] poll_count
);
   logic [3:0] wait_reg;
   always_ff @(posedge core_clk) begin
      poll_done <= 1'b0;
      if (rst) begin
         wait_reg <= 4'h0;
         last_byte <= 8'h00;
         poll_count <= 8'h00;
      end else if (poll_go && !poll_done) begin
         // slow controller: idles poll_wait cycles first
         if (wait_reg < poll_wait) begin
            wait_reg <= wait_reg + 4'h1;
         end else begin
            last_byte <= poll_byte; // byte taken at the poll edge
            poll_done <= 1'b1;
            poll_count <= poll_count + 8'h01;
            wait_reg <= 4'h0;
         end
      end
   end
endmodule // ssrl_poll_ctrl

/* File: tb/ssrl_status_core_bench.sv */
/*
 self-checking bench for the status and service request core.
 assumes 10 MHz core_clk and the poll controller model beside it.
*/
`timescale 1ns/1ns
module ssrl_status_core_bench;
   logic core_clk = 1'b0, rst = 1'b1, r_wr = 1'b0, r_rd = 1'b0, en_sel = 1'b0;
   logic clr = 1'b0, pre = 1'b0, sem = 1'b0, trig = 1'b0, opcq = 1'b0, opsp = 1'b0;
   logic swp = 1'b0, avc = 1'b0, calok = 1'b0, errp = 1'b0, msgp = 1'b0, go = 1'b0;
   ssrl_pkg::ssrl_sel_t sel = ssrl_pkg::SSRL_SEL_STD;
   logic [15:0] wdata = 16'h0000, rdata, q;
   logic [15:0] std_in = 16'h0000, oper_in = 16'h0000, meas_in = 16'h0000;
   logic [15:0] ques_in = 16'h0000, m;
   logic [7:0] pbyte, lastb, pcnt;
   logic [3:0] pw = 4'h0;
   logic srq, pdone;
   int bad_count = 0, checked = 0;

   initial begin
      forever #50 core_clk = ~core_clk;
   end

   ssrl_status_core u_dut (.core_clk(core_clk), .rst(rst), .reg_wr(r_wr), .reg_rd(r_rd),
      .reg_sel(sel), .reg_wdata(wdata), .en_sel(en_sel), .reg_rdata(rdata),
      .clear_status(clr), .status_preset(pre), .poll_done(pdone), .poll_byte(pbyte),
      .service_request(srq), .opc_query(opcq), .ops_pending(opsp),
      .empty_queue_read(std_in[2]), .device_error(std_in[3]), .exec_error(std_in[4]),
      .syntax_error(std_in[5]), .semantic_error(sem), .trigger_in_message(trig),
      .local_key(std_in[6]), .self_adjust(oper_in[0]), .av_ohms_running(oper_in[1]),
      .sweep_running(oper_in[3]), .awaiting_trigger_bus(oper_in[5]),
      .awaiting_arm(oper_in[6]), .idle(oper_in[10]), .low_limit1_fail(meas_in[1]),
      .high_limit1_fail(meas_in[2]), .low_limit2_fail(meas_in[3]),
      .high_limit2_fail(meas_in[4]), .limits_pass(meas_in[5]),
      .reading_ready(meas_in[6]), .reading_overflow(meas_in[7]),
      .buffer_has_two(meas_in[8]), .buffer_full(meas_in[9]), .sweep_done(swp),
      .av_cycles_done(avc), .input_overvoltage(meas_in[10]),
      .output_lockout(meas_in[11]), .source_in_compliance(meas_in[14]),
      .bad_trim_constant(ques_in[7]), .calibration_ok(calok),
      .param_ignored(ques_in[14]), .error_pending(errp), .message_pending(msgp));

   ssrl_poll_ctrl u_ctrl (.core_clk(core_clk), .rst(rst), .poll_go(go), .poll_wait(pw),
      .poll_byte(pbyte), .poll_done(pdone), .last_byte(lastb), .poll_count(pcnt));

   task check(string what, logic [15:0] seen, logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task tick(int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task wr(ssrl_pkg::ssrl_sel_t s, logic e, logic [15:0] d);
      @(posedge core_clk);
      r_wr <= 1'b1;
      sel <= s;
      en_sel <= e;
      wdata <= d;
      @(posedge core_clk);
      r_wr <= 1'b0;
   endtask
   task rd(ssrl_pkg::ssrl_sel_t s, logic e);
      @(posedge core_clk);
      r_rd <= 1'b1;
      sel <= s;
      en_sel <= e;
      @(posedge core_clk);
      r_rd <= 1'b0;
      tick(1);
      q = rdata;
   endtask
   // one-cycle pulse on one event cause; flag latches at the second edge
   task hit(int s, int b);
      @(posedge core_clk);
      case (s)
         0: std_in[b] <= 1'b1;
         1: oper_in[b] <= 1'b1;
         2: meas_in[b] <= 1'b1;
         default: ques_in[b] <= 1'b1;
      endcase
      @(posedge core_clk);
      std_in <= '0;
      oper_in <= '0;
      meas_in <= '0;
      ques_in <= '0;
   endtask
   task strobe(logic k);
      @(posedge core_clk);
      if (k) clr <= 1'b1;
      else pre <= 1'b1;
      @(posedge core_clk);
      clr <= 1'b0;
      pre <= 1'b0;
   endtask
   // slow or prompt serial poll, bounded wait on the controller
   task poll(logic [3:0] w);
      int n;
      logic [7:0] c0;
      c0 = pcnt;
      n = 0;
      @(posedge core_clk);
      go <= 1'b1;
      pw <= w;
      while (pcnt === c0 && n < 40) begin
         tick(1);
         n++;
      end
      @(posedge core_clk);
      go <= 1'b0;
      tick(0);
      check("poll count", {8'h00, pcnt}, {8'h00, c0 + 8'h01});
   endtask

   task t_reset;
      rd(ssrl_pkg::SSRL_SEL_SRE, 1'b0); check("mask at reset", q, 16'h0000);
      rd(ssrl_pkg::SSRL_SEL_STD, 1'b0); check("power on flag", q, 16'h0080);
      rd(ssrl_pkg::SSRL_SEL_STD, 1'b0); check("std after read", q, 16'h0000);
   endtask
   task t_mask;
      wr(ssrl_pkg::SSRL_SEL_SRE, 1'b0, 16'h00FF);
      wr(ssrl_pkg::SSRL_SEL_STD, 1'b1, 16'hFFFF);
      rd(ssrl_pkg::SSRL_SEL_STD, 1'b1); check("std enable", q, 16'h00FD);
      strobe(1'b1);
      strobe(1'b0);
      rd(ssrl_pkg::SSRL_SEL_SRE, 1'b0); check("mask kept", q, 16'h00FF);
      rd(ssrl_pkg::SSRL_SEL_STD, 1'b1); check("enable preset", q, 16'h0000);
      wr(ssrl_pkg::SSRL_SEL_SRE, 1'b0, 16'h0000);
      rd(ssrl_pkg::SSRL_SEL_SRE, 1'b0); check("mask zero", q, 16'h0000);
   endtask
   // each vector-driven cause alone lands on its own bit; the shared causes are checked together
   task t_events;
      for (int s = 0; s < 4; s++) begin
         m = s == 0 ? 16'h007C : s == 1 ? 16'(ssrl_pkg::OPER_USED_MASK) :
             s == 2 ? 16'(ssrl_pkg::MEAS_USED_MASK) : 16'(ssrl_pkg::QUES_USED_MASK);
         for (int b = 0; b < 16; b++) begin
            if (m[b]) begin
               strobe(1'b1);
               hit(s, b);
               rd(ssrl_pkg::ssrl_sel_t'(s), 1'b0);
               check("event bit", q, 16'h0001 << b);
            end
         end
      end
      @(posedge core_clk);
      sem <= 1'b1;
      swp <= 1'b1;
      @(posedge core_clk);
      sem <= 1'b0;
      swp <= 1'b0;
      trig <= 1'b1;
      avc <= 1'b1;
      @(posedge core_clk);
      trig <= 1'b0;
      avc <= 1'b0;
      rd(ssrl_pkg::SSRL_SEL_STD, 1'b0); check("command error", q, 16'h0020);
      rd(ssrl_pkg::SSRL_SEL_MEAS, 1'b0); check("sweep cycles", q, 16'h0200);
      hit(2, 6);
      strobe(1'b1);
      rd(ssrl_pkg::SSRL_SEL_MEAS, 1'b0); check("clear status", q, 16'h0000);
   endtask
   task t_opc;
      @(posedge core_clk);
      opsp <= 1'b1;
      opcq <= 1'b1;
      @(posedge core_clk);
      opcq <= 1'b0;
      rd(ssrl_pkg::SSRL_SEL_STD, 1'b0); check("opc pending", q, 16'h0000);
      @(posedge core_clk);
      opsp <= 1'b0;
      tick(3);
      rd(ssrl_pkg::SSRL_SEL_STD, 1'b0); check("opc done", q, 16'h0001);
   endtask
   task t_walk;
      wr(ssrl_pkg::SSRL_SEL_SRE, 1'b0, 16'h0014);
      @(posedge core_clk);
      errp <= 1'b1;
      tick(2);
      check("request line", {15'h0, srq}, 16'h0001);
      check("poll byte", {8'h00, pbyte}, 16'h0044);
      poll(4'h0);
      check("polled byte", {8'h00, lastb}, 16'h0044);
      check("line after poll", {15'h0, srq}, 16'h0000);
      check("byte after poll", {8'h00, pbyte}, 16'h0004);
      rd(ssrl_pkg::SSRL_SEL_STB, 1'b0); check("master kept", q, 16'h0044);
      // second source rises while the first still stands
      @(posedge core_clk);
      msgp <= 1'b1;
      tick(2);
      check("second source", {15'h0, srq}, 16'h0001);
      check("second byte", {8'h00, pbyte}, 16'h0054);
      @(posedge core_clk);
      errp <= 1'b0;
      rd(ssrl_pkg::SSRL_SEL_STB, 1'b0); check("live summary", q, 16'h0050);
      @(posedge core_clk);
      msgp <= 1'b0;
   endtask
   task t_again;
      wr(ssrl_pkg::SSRL_SEL_MEAS, 1'b1, 16'h0200);
      wr(ssrl_pkg::SSRL_SEL_SRE, 1'b0, 16'h0001);
      hit(2, 9);
      tick(2);
      check("meas request", {15'h0, srq}, 16'h0001);
      poll(4'h5);
      check("slow poll byte", {8'h00, lastb}, 16'h0041);
      check("line cleared", {15'h0, srq}, 16'h0000);
      hit(2, 9);
      tick(2);
      check("fresh request", {15'h0, srq}, 16'h0001);
      poll(4'h1);
      rd(ssrl_pkg::SSRL_SEL_MEAS, 1'b0); check("meas flags", q, 16'h0200);
      rd(ssrl_pkg::SSRL_SEL_STB, 1'b0); check("master low", q, 16'h0000);
   endtask

   task wrap_up;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // whole run is a few hundred cycles
   initial begin
      #5000000;
      bad_count++;
      wrap_up;
   end

   initial begin
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      t_reset;
      t_mask;
      t_events;
      t_opc;
      t_walk;
      t_again;
      wrap_up;
   end
endmodule // ssrl_status_core_bench
